//--- src/vcf_map.svh
// Register map, field positions, reset values and counts of the calibration block
//
// What this block does
// - Three monitors flag references or oscillator too slow
// - Oscillator monitor watches external clock when selected
// - One bit picks normal or extended reference threshold
// - Sequencer timed from divided reference, not oscillator
// - Auto-load strap starts calibration; needs live reference
// - Zero-to-one calibrate transition after update starts calibration
// - Read-only bit shows calibration finished
// - Sync outputs, calibrate, release sync, close loop
// - Sync released without waiting for lock
// - Calibration clock is phase detector over divider
// - Calibration lasts fixed count of calibration clocks
// - No calibration from loop register changes alone
`ifndef VCF_MAP_SVH
`define VCF_MAP_SVH

`define VCF_ADDR_W         10
`define VCF_OFS_PLL_CTRL   10'h018
`define VCF_OFS_LD_MON     10'h01a
`define VCF_OFS_STATUS     10'h01f
`define VCF_OFS_POST_DIV   10'h1e0
`define VCF_OFS_UPDATE     10'h232

`define VCF_BIT_CAL_REQ    0
`define VCF_CALDIV_LSB     1
`define VCF_CALDIV_MSB     2
`define VCF_BIT_MON_EXT    6
`define VCF_BIT_CAL_DONE   6
`define VCF_BIT_REF1_LOW   0
`define VCF_BIT_REF2_LOW   1
`define VCF_BIT_OSC_LOW    2
`define VCF_BIT_UPDATE     0

`define VCF_RST_PLL_CTRL   8'h00
`define VCF_RST_LD_MON     8'h00
`define VCF_RST_POST_DIV   8'h00

`define VCF_CAL_CYCLES     4400

`endif

//--- src/vcf_pkg.sv
// Types shared by the calibration block
`default_nettype none
package vcf_pkg;
  typedef logic [7:0] vcf_reg_t;
  typedef enum logic [2:0] {
    VCF_IDLE,
    VCF_SYNC,
    VCF_CAL,
    VCF_RELEASE,
    VCF_CLOSE
  } vcf_state_t;
endpackage
`default_nettype wire

//--- src/vcf_mon_if.sv
// Carrier between the sequencer top and the frequency monitors
`default_nettype none
interface vcf_mon_if;
  logic [2:0] edge_seen;
  logic       thresh_ext;
  logic [2:0] too_slow;
  modport top (output edge_seen, output thresh_ext, input too_slow);
  modport mon (input edge_seen, input thresh_ext, output too_slow);
endinterface
`default_nettype wire

//--- src/vcf_freq_mon.sv
// Three frequency status monitors counting cycles between input edges
`default_nettype none
module vcf_freq_mon
  import vcf_pkg::*;
#(
  parameter int          CNT_W      = 16,
  parameter logic [15:0] REF_NORMAL = 16'h0040,
  parameter logic [15:0] REF_EXTEND = 16'h0400,
  parameter logic [15:0] OSC_LIMIT  = 16'h0040
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Edges and flags
  vcf_mon_if.mon    mon
);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_mon
      logic [CNT_W-1:0] gap_q;
      logic [CNT_W-1:0] limit;
      logic             slow_q;
      // Channel 2 is the oscillator or external clock monitor
      assign limit = (g == 2) ? OSC_LIMIT[CNT_W-1:0] :
                     (mon.thresh_ext ? REF_EXTEND[CNT_W-1:0] :
                                       REF_NORMAL[CNT_W-1:0]);
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          gap_q  <= '0;
          slow_q <= 1'b0;
        end else if (mon.edge_seen[g]) begin
          gap_q  <= '0;
          slow_q <= 1'b0;
        end else if (gap_q >= limit) begin
          slow_q <= 1'b1;
        end else begin
          gap_q <= gap_q + 1'b1;
        end
      end
      assign mon.too_slow[g] = slow_q;
    end
  endgenerate

endmodule
`default_nettype wire

//--- src/vcf_top.sv
// Calibration sequencer, staged registers and frequency monitor wiring
`default_nettype none
`include "vcf_map.svh"
module vcf_top
  import vcf_pkg::*;
#(
  parameter int R_W       = 14,
  parameter int CAL_COUNT = `VCF_CAL_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Register access port
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [`VCF_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  output var  logic [7:0]            reg_rdata_out,
  // Pins from outside the clock domain
  input  wire logic                  ref1_clk_in,
  input  wire logic                  ref2_clk_in,
  input  wire logic                  osc_clk_in,
  input  wire logic                  ext_clk_in,
  input  wire logic                  ext_clk_sel_in,
  input  wire logic                  autoload_strap_in,
  // Loop configuration from the same clock
  input  wire logic [R_W-1:0]        r_divider_in,
  // Sequencer outputs and active post-divider setting
  output var  logic                  sync_hold_out,
  output var  logic                  cal_run_out,
  output var  logic                  loop_closed_out,
  output var  logic                  cal_done_out,
  output var  logic [2:0]            post_div_out,
  // Monitor outputs
  output logic                       ref1_low_out,
  output logic                       ref2_low_out,
  output logic                       osc_low_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  logic [5:0] pin_raw;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] rise;

  assign pin_raw = {autoload_strap_in, ext_clk_sel_in, ext_clk_in,
                    osc_clk_in, ref2_clk_in, ref1_clk_in};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q[3:0];
    end
  end

  assign rise = s2_q[3:0] & ~s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Staged and active registers
  vcf_reg_t stg_ctrl_q;
  vcf_reg_t stg_mon_q;
  vcf_reg_t stg_post_q;
  vcf_reg_t act_ctrl_q;
  vcf_reg_t act_mon_q;
  vcf_reg_t act_post_q;
  logic     update;

  // Transfer strobe moves every staged value at once
  assign update = reg_wr_in && (reg_addr_in == `VCF_OFS_UPDATE)
                  && reg_wdata_in[`VCF_BIT_UPDATE];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stg_ctrl_q <= `VCF_RST_PLL_CTRL;
      stg_mon_q  <= `VCF_RST_LD_MON;
      stg_post_q <= `VCF_RST_POST_DIV;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `VCF_OFS_PLL_CTRL: stg_ctrl_q <= reg_wdata_in;
        `VCF_OFS_LD_MON:   stg_mon_q  <= reg_wdata_in;
        `VCF_OFS_POST_DIV: stg_post_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_ctrl_q <= `VCF_RST_PLL_CTRL;
      act_mon_q  <= `VCF_RST_LD_MON;
      act_post_q <= `VCF_RST_POST_DIV;
    end else if (update) begin
      act_ctrl_q <= stg_ctrl_q;
      act_mon_q  <= stg_mon_q;
      act_post_q <= stg_post_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      post_div_out <= 3'h0;
    end else begin
      post_div_out <= act_post_q[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start request: explicit transition or power-up auto-load
  logic       req_prev_q;
  logic [1:0] strap_wait_q;
  logic       auto_pend_q;
  logic       start;
  vcf_state_t state_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= act_ctrl_q[`VCF_BIT_CAL_REQ];
    end
  end

  // Strap sampled once the synchroniser has filled after release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_wait_q <= 2'h0;
      auto_pend_q  <= 1'b0;
    end else if (strap_wait_q != 2'h3) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2) begin
        auto_pend_q <= s2_q[5];
      end
    end else if (start) begin
      auto_pend_q <= 1'b0;
    end
  end

  // Only the request bit edge or the strap start a run
  assign start = (state_q == VCF_IDLE) &&
                 ((act_ctrl_q[`VCF_BIT_CAL_REQ] && !req_prev_q) || auto_pend_q);

  ////////////////////////////////////////////////////////////////////////
  // Calibration clock from divided reference
  logic [R_W-1:0] r_cnt_q;
  logic [3:0]     div_cnt_q;
  logic [3:0]     div_last;
  logic           pd_tick;
  logic           cal_tick;

  assign pd_tick = rise[0] && (r_cnt_q >= r_divider_in - 1'b1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_cnt_q <= '0;
    end else if (start || pd_tick) begin
      r_cnt_q <= '0;
    end else if (rise[0]) begin
      r_cnt_q <= r_cnt_q + 1'b1;
    end
  end

  // Divide by 2, 4, 8 or 16
  always_comb begin
    case (act_ctrl_q[`VCF_CALDIV_MSB:`VCF_CALDIV_LSB])
      2'h0:    div_last = 4'h1;
      2'h1:    div_last = 4'h3;
      2'h2:    div_last = 4'h7;
      default: div_last = 4'hf;
    endcase
  end

  assign cal_tick = pd_tick && (div_cnt_q >= div_last);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_q <= 4'h0;
    end else if (start || cal_tick) begin
      div_cnt_q <= 4'h0;
    end else if (pd_tick) begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [12:0] cyc_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= VCF_IDLE;
    end else begin
      case (state_q)
        VCF_IDLE:    if (start) state_q <= VCF_SYNC;
        VCF_SYNC:    if (cal_tick) state_q <= VCF_CAL;
        VCF_CAL: begin
          if (cal_tick && cyc_q == 13'(CAL_COUNT - 1)) state_q <= VCF_RELEASE;
        end
        // Sync drops here, before the loop has locked
        VCF_RELEASE: if (cal_tick) state_q <= VCF_CLOSE;
        VCF_CLOSE:   state_q <= VCF_IDLE;
        default:     state_q <= VCF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_q <= 13'h0;
    end else if (state_q != VCF_CAL) begin
      cyc_q <= 13'h0;
    end else if (cal_tick) begin
      cyc_q <= cyc_q + 13'h1;
    end
  end

  // Outputs held static, then released, then loop closed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_hold_out   <= 1'b0;
      cal_run_out     <= 1'b0;
      loop_closed_out <= 1'b1;
    end else begin
      sync_hold_out   <= (state_q == VCF_SYNC) || (state_q == VCF_CAL);
      cal_run_out     <= (state_q != VCF_IDLE);
      loop_closed_out <= (state_q == VCF_IDLE) || (state_q == VCF_CLOSE);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_done_out <= 1'b0;
    end else if (start) begin
      cal_done_out <= 1'b0;
    end else if (state_q == VCF_CLOSE) begin
      cal_done_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency monitors
  vcf_mon_if mon_bus ();

  assign mon_bus.edge_seen  = {(s2_q[4] ? rise[3] : rise[2]), rise[1], rise[0]};
  assign mon_bus.thresh_ext = act_mon_q[`VCF_BIT_MON_EXT];

  vcf_freq_mon u_mon (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .mon    (mon_bus.mon)
  );

  assign ref1_low_out = mon_bus.too_slow[0];
  assign ref2_low_out = mon_bus.too_slow[1];
  assign osc_low_out  = mon_bus.too_slow[2];

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `VCF_OFS_PLL_CTRL: reg_rdata_out <= act_ctrl_q;
        `VCF_OFS_LD_MON:   reg_rdata_out <= act_mon_q;
        `VCF_OFS_POST_DIV: reg_rdata_out <= act_post_q;
        `VCF_OFS_STATUS: begin
          reg_rdata_out <= {1'b0, cal_done_out, 3'h0, mon_bus.too_slow};
        end
        default:           reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- verif/vcf_sva.sv
// Checker on the calibration block ports
`default_nettype none
module vcf_sva #(
  parameter int R_W       = 14,
  parameter int CAL_COUNT = 4400
) (
  // Clock and reset
  input wire logic           clk_in,
  input wire logic           rst_in,
  // Register port
  input wire logic           reg_wr_in,
  input wire logic           reg_rd_in,
  input wire logic [9:0]     reg_addr_in,
  input wire logic [7:0]     reg_rdata_out,
  // Pins
  input wire logic           ref1_clk_in,
  input wire logic           osc_clk_in,
  input wire logic           ext_clk_in,
  input wire logic           ext_clk_sel_in,
  input wire logic           autoload_strap_in,
  input wire logic [R_W-1:0] r_divider_in,
  // Outputs
  input wire logic           sync_hold_out,
  input wire logic           cal_run_out,
  input wire logic           loop_closed_out,
  input wire logic           cal_done_out,
  input wire logic           ref1_low_out,
  input wire logic           osc_low_out
);
  logic [3:0]  age_q;
  logic [11:0] st1_q;
  logic [11:0] stm_q;
  logic        r1_q;
  logic        pm_q;
  int          edges_q;
  wire logic   pin_m = ext_clk_sel_in ? ext_clk_in : osc_clk_in;
  ////////////////////////////////////////////////////////////////
  // Cycles since last write to the update register, whatever its data
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) age_q <= 4'hf;
    else if (reg_wr_in && reg_addr_in == 10'h232) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  // Pin history and stall counts
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) begin
      r1_q <= 1'b0;
      pm_q <= 1'b0;
      st1_q <= 12'h000;
      stm_q <= 12'h000;
    end else begin
      r1_q <= ref1_clk_in;
      pm_q <= pin_m;
      st1_q <= (ref1_clk_in != r1_q) ? 12'h000 : (&st1_q ? st1_q : st1_q + 12'h001);
      stm_q <= (pin_m != pm_q) ? 12'h000 : (&stm_q ? stm_q : stm_q + 12'h001);
    end
  // Reference edges while outputs held
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) edges_q <= 0;
    else if (!sync_hold_out) edges_q <= 0;
    else if (ref1_clk_in && !r1_q) edges_q <= edges_q + 1;
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_sync_opens_loop: assert property (sync_hold_out |-> !loop_closed_out && cal_run_out)
    else $error("loop closed or idle while outputs held");
  a_start_clears_done: assert property ($rose(sync_hold_out) |-> !cal_done_out)
    else $error("done still set at calibration start");
  a_done_needs_run: assert property ($fell(cal_done_out) |=> cal_run_out)
    else $error("done cleared without a calibration");
  a_release_first: assert property ($fell(sync_hold_out) |-> !loop_closed_out && !cal_done_out)
    else $error("sync released after loop close or done");
  a_close_after_sync: assert property ($rose(loop_closed_out) |-> !sync_hold_out)
    else $error("loop closed while outputs held");
  a_cal_length: assert property ($fell(sync_hold_out) |->
    edges_q >= 2 * CAL_COUNT * int'(r_divider_in))
    else $error("calibration shorter than its count");
  a_start_on_request: assert property ($rose(cal_run_out) |->
    age_q < 4'h6 || autoload_strap_in)
    else $error("calibration started without a request");
  a_done_readback: assert property (reg_rd_in && reg_addr_in == 10'h01f |=>
    reg_rdata_out[6] == $past(cal_done_out))
    else $error("status done bit differs from done output");
  a_ref_flag_slow: assert property ($rose(ref1_low_out) |-> st1_q >= 12'h030)
    else $error("reference flag raised while clock running");
  a_osc_flag_slow: assert property ($rose(osc_low_out) |-> stm_q >= 12'h030)
    else $error("oscillator flag raised on wrong or running input");
endmodule
`default_nettype wire

//--- verif/vcf_host.sv
// Host software model on the register port
`default_nettype none
module vcf_host (
  // Clock
  input wire logic        clk_in,
  // Register port
  input wire logic [7:0]  reg_rdata_in,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [9:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 10'h000;
    reg_wdata_out = 8'h00;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
  endtask
  // Loop set and reference stable before any start
  task automatic start(input logic [1:0] f);
    wr(10'h018, {5'h00, f, 1'b1});
    wr(10'h232, 8'h01);
  endtask
  task automatic recal(input logic [1:0] f);
    wr(10'h018, {5'h00, f, 1'b0});
    wr(10'h232, 8'h01);
    start(f);
  endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the calibration block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CAL_COUNT = 8;
  typedef struct {logic [9:0] a; logic [7:0] d; logic [7:0] e;} vcf_row_t;
  vcf_row_t    rows [6] = '{'{10'h1e0, 8'h05, 8'h05}, '{10'h01a, 8'h40, 8'h40},
    '{10'h01a, 8'h00, 8'h00}, '{10'h100, 8'hff, 8'h00}, '{10'h01f, 8'hff, 8'h00},
    '{10'h018, 8'h06, 8'h06}};
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        sel = 1'b0;
  logic        strap = 1'b0;
  logic        ph = 1'b0;
  logic [3:0]  run = 4'hf;
  logic [13:0] r_div = 14'h0001;
  logic        wr, rd, sync, crun, loopc, done, l1, l2, lo;
  logic [9:0]  addr;
  logic [7:0]  wdata, rdata, d;
  logic [2:0]  pdiv;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  initial forever #25 clk_in = ~clk_in;
  always #100 ph = ~ph;
  vcf_top #(.CAL_COUNT(CAL_COUNT)) i_vcf_top (.clk_in, .rst_in, .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .ref1_clk_in(ph & run[0]), .ref2_clk_in(ph & run[1]), .osc_clk_in(ph & run[2]),
    .ext_clk_in(ph & run[3]), .ext_clk_sel_in(sel), .autoload_strap_in(strap),
    .r_divider_in(r_div), .sync_hold_out(sync), .cal_run_out(crun),
    .loop_closed_out(loopc), .cal_done_out(done), .post_div_out(pdiv),
    .ref1_low_out(l1), .ref2_low_out(l2), .osc_low_out(lo));
  vcf_host i_vcf_host (.clk_in, .reg_rdata_in(rdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cal_wait(input int div);
    int n = 0;
    while (sync !== 1'b1 && n < 40) begin @(negedge clk_in); n++; end
    chk({7'h00, done}, 8'h00);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin @(negedge clk_in); n++; end
    chk({6'h00, sync, loopc}, 8'h01);
    chk({6'h00, n >= CAL_COUNT * r_div * div * 4, n <= (CAL_COUNT + 3) * r_div * div * 4},
      8'h03);
    i_vcf_host.rd(10'h01f, d);
    chk(d & 8'h40, 8'h40);
    $display("test calibration done");
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk({4'h0, sync, crun, loopc, done}, 8'h02);
    $display("test reset done");
    foreach (rows[i]) begin
      i_vcf_host.wr(rows[i].a, rows[i].d);
      i_vcf_host.wr(10'h232, 8'h01);
      i_vcf_host.rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk({5'h00, pdiv}, 8'h05);
    $display("test registers done");
    i_vcf_host.start(2'h3);
    cal_wait(16);
    r_div = 14'h0002;
    i_vcf_host.start(2'h3);
    repeat (40) @(negedge clk_in);
    chk({6'h00, crun, done}, 8'h01);
    $display("test no self start done");
    for (int f = 0; f < 3; f++) begin
      i_vcf_host.recal(f[1:0]);
      cal_wait(2 << f);
    end
    run[1] = 1'b0;
    repeat (96) @(negedge clk_in);
    i_vcf_host.rd(10'h01f, d);
    chk({l2, d[2:0]}, 8'h0a);
    run[1] = 1'b1;
    repeat (10) @(negedge clk_in);
    chk({7'h00, l2}, 8'h00);
    i_vcf_host.wr(10'h01a, 8'h40);
    i_vcf_host.wr(10'h232, 8'h01);
    run[1] = 1'b0;
    repeat (128) @(negedge clk_in);
    chk({7'h00, l2}, 8'h00);
    run[1] = 1'b1;
    run[2] = 1'b0;
    sel = 1'b1;
    repeat (128) @(negedge clk_in);
    chk({7'h00, lo}, 8'h00);
    sel = 1'b0;
    repeat (96) @(negedge clk_in);
    chk({7'h00, lo}, 8'h01);
    run[2] = 1'b1;
    $display("test monitors done");
    rst_in = 1'b1;
    strap = 1'b1;
    run[0] = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (300) @(negedge clk_in);
    chk({5'h00, crun, done, l1}, 8'h05);
    run[0] = 1'b1;
    cal_wait(2);
    complete_run();
  end
endmodule
bind vcf_top vcf_sva #(.R_W(R_W), .CAL_COUNT(CAL_COUNT)) i_vcf_sva (.clk_in, .rst_in,
  .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .ref1_clk_in, .osc_clk_in,
  .ext_clk_in, .ext_clk_sel_in, .autoload_strap_in, .r_divider_in, .sync_hold_out,
  .cal_run_out, .loop_closed_out, .cal_done_out, .ref1_low_out, .osc_low_out);
`default_nettype wire
